// [beam_setting_memory_and_load.v]
// transmit beam memory, holding/working gain and phase registers, load strobes
//
// Operation
// R1 - address bit 14 matches high chip pin, 13 low pin, bits 12:11 both one
// R2 - beam entry is 24 bits over three byte addresses, low first, fourth unused
// R3 - channel in address bits 3:2, beam position index in bits 10:4
// R4 - transmit memory stores every beam position for all four channels
// R5 - bias setting is 80 bits in a sixteen-address slot after beams
// R6 - seven bias settings in consecutive slots, same byte layout
// R7 - unused addresses ignore writes and read back zero
// R8 - gain byte: seven bits amplifier code, eighth bit attenuator state
// R9 - host writes receive gains and phases at offsets 0x010 to 0x01B
// R10 - host writes transmit gains and phases at offsets 0x01C to 0x027
// R11 - gain/phase writes land in holding registers until a load bit pulses
// R12 - a load pulse copies holding into working for its direction
// R13 - a rising load pin performs the same transfer as the load bit
// R14 - working registers keep driving while holding registers are rewritten
// R15 - holding registers load from bus writes or from memory recall
// R16 - each load strobe rising edge gives exactly one transfer
// R17 - writing an index to 0x039 or 0x03A recalls an entry; here only a 0x03A write recalls, 0x039 only stores the index
// R18 - recalled settings wait for the matching load command
// R19 - bus gain/phase values are used only with memory bypass bit high
// R20 - attenuator bit high bypasses the step attenuator, low switches it in
//
// The Avalon-MM register port and the register offsets were decided locally.
`include "beam_setting_consts.vh"

module beam_setting_memory_and_load #(
	parameter ADDR_W = 17,
	parameter CHANNELS = 4
) (
	input  wire                  clk_sys,
	input  wire                  reset_n,
	input  wire [ADDR_W-1:0]     avs_address,
	input  wire                  avs_read,
	input  wire                  avs_write,
	input  wire [31:0]           avs_writedata,
	input  wire [3:0]            avs_byteenable,
	output wire [31:0]           avs_readdata,
	output wire                  avs_waitrequest,
	input  wire                  chipAddrPinLow,
	input  wire                  chipAddrPinHigh,
	input  wire                  rxLoadPin,
	input  wire                  txLoadPin,
	output wire [8*CHANNELS-1:0] rxWorkGain,
	output wire [16*CHANNELS-1:0] rxWorkPhase,
	output wire [8*CHANNELS-1:0] txWorkGain,
	output wire [16*CHANNELS-1:0] txWorkPhase,
	output wire [7*CHANNELS-1:0] rxGainCode,
	output wire [7*CHANNELS-1:0] txGainCode,
	output wire [CHANNELS-1:0]   rxAttenuatorBypassBit,
	output wire [CHANNELS-1:0]   txAttenuatorBypassBit,
	output wire                  memBypass
);

	localparam HOLD_W = 8 * `BYTES_PER_DIR;
	localparam GAIN_W = 8 * CHANNELS;
	localparam ST_IDLE = 1'b0;
	localparam ST_RECALL = 1'b1;

	reg  [HOLD_W-1:0] rxHoldQ;
	reg  [HOLD_W-1:0] txHoldQ;
	reg  [HOLD_W-1:0] rxWorkQ;
	reg  [HOLD_W-1:0] txWorkQ;
	reg  [1:0]        loadBitsQ;
	reg  [1:0]        loadPinsQ;
	reg  [7:0]        memCtrlQ;
	reg  [6:0]        rxRecallIdxQ;
	reg  [6:0]        txRecallIdxQ;
	reg               stateQ;
	reg  [1:0]        recallChanQ;
	reg               waitQ;
	reg  [31:0]       readDataQ;
	reg  [23:0]       beamMem [0:`BEAM_ENTRIES-1];
	reg  [7:0]        biasMem [0:`BIAS_BYTES-1];

	wire [14:0] idx;
	wire        chipMatch;
	wire        txRegion;
	wire [6:0]  beamPos;
	wire [1:0]  beamChan;
	wire [1:0]  beamByte;
	wire        beamHit;
	wire [8:0]  beamIdx;
	wire [4:0]  biasMap;
	wire [2:0]  biasSet;
	wire        biasHit;
	wire [6:0]  biasIdx;
	wire        regHit;
	wire        selRxHold;
	wire        selTxHold;
	wire        selLoadCtrl;
	wire        selMemCtrl;
	wire        selRxRecall;
	wire        selTxRecall;
	wire        selStatus;
	wire        busReq;
	wire        busAccept;
	wire        wrStrobe;
	wire [7:0]  wrByte;
	wire [1:0]  loadRise;
	wire        doRxLoad;
	wire        doTxLoad;
	wire [8:0]  recallIdx;
	wire [23:0] recallWord;
	wire        recallValid;
	wire [23:0] beamOld;
	reg  [23:0] beamNew;
	reg  [7:0]  regRead;
	reg  [31:0] readNext;

	// bias slot byte layout: 0,1,2,4,5,6,8,9,12,13 hold bytes 0..9
	function [4:0] biasByteMap;
		input [3:0] ofs;
		begin
			case (ofs)
				4'h0: biasByteMap = 5'h10;
				4'h1: biasByteMap = 5'h11;
				4'h2: biasByteMap = 5'h12;
				4'h4: biasByteMap = 5'h13;
				4'h5: biasByteMap = 5'h14;
				4'h6: biasByteMap = 5'h15;
				4'h8: biasByteMap = 5'h16;
				4'h9: biasByteMap = 5'h17;
				4'hc: biasByteMap = 5'h18;
				4'hd: biasByteMap = 5'h19;
				default: biasByteMap = 5'h00;
			endcase
		end
	endfunction

	// address decode; registers and memory both answer only to this chip
	assign idx = avs_address[16:2];
	assign chipMatch = (idx[`ADDR_CHIP_HIGH] == chipAddrPinHigh) &&
		(idx[`ADDR_CHIP_LOW] == chipAddrPinLow); // R1
	assign txRegion = chipMatch &&
		({idx[`ADDR_REGION_HI], idx[`ADDR_REGION_LO]} == `TX_REGION_CODE); // R1
	assign beamPos = idx[10:4]; // R3
	assign beamChan = idx[3:2]; // R3
	assign beamByte = idx[1:0]; // R2
	assign beamHit = txRegion && (beamPos <= `LAST_BEAM_POS) &&
		(beamByte != `UNUSED_BEAM_BYTE); // R2 R4 R7
	assign beamIdx = {beamPos, beamChan};
	assign biasMap = biasByteMap(idx[3:0]); // R5
	assign biasSet = beamPos[2:0] - 3'h1;
	assign biasHit = txRegion && (beamPos >= `FIRST_BIAS_SLOT) && biasMap[4]; // R5 R6 R7
	assign biasIdx = biasSet * 7'd10 + {3'h0, biasMap[3:0]}; // R6
	assign regHit = chipMatch && (idx[12:0] < `OFS_REG_LIMIT);

	// register selects, each gated by the chip pins through regHit
	assign selRxHold = regHit && (idx[12:0] >= `OFS_RX_HOLD_FIRST) &&
		(idx[12:0] <= `OFS_RX_HOLD_LAST);
	assign selTxHold = regHit && (idx[12:0] >= `OFS_TX_HOLD_FIRST) &&
		(idx[12:0] <= `OFS_TX_HOLD_LAST);
	assign selLoadCtrl = regHit && (idx[12:0] == `OFS_LOAD_CTRL);
	assign selMemCtrl = regHit && (idx[12:0] == `OFS_MEM_CTRL);
	assign selRxRecall = regHit && (idx[12:0] == `OFS_RX_RECALL);
	assign selTxRecall = regHit && (idx[12:0] == `OFS_TX_RECALL);
	assign selStatus = regHit && (idx[12:0] == `OFS_STATUS);

	// bus handshake: requests wait while a recall rewrites the tx holding bytes
	// stalling is cheaper than arbitrating a bus write against the recall copy
	assign busReq = avs_read || avs_write;
	assign busAccept = busReq && waitQ && (stateQ == ST_IDLE);
	assign wrStrobe = avs_write && !waitQ && avs_byteenable[0];
	assign wrByte = avs_writedata[7:0];

	// beam entry byte merge for a single byte write
	assign beamOld = beamMem[beamIdx];
	always @* begin
		beamNew = beamOld;
		case (beamByte)
			2'h0: beamNew[7:0] = wrByte; // R2
			2'h1: beamNew[15:8] = wrByte; // R2
			default: beamNew[23:16] = wrByte; // R2
		endcase
	end

	// memory arrays carry no reset; contents are whatever software stored
	// a byte read before it is ever written comes back unknown
	always @(posedge clk_sys) begin
		if (wrStrobe && beamHit) begin
			beamMem[beamIdx] <= beamNew;
		end
		if (wrStrobe && biasHit) begin
			biasMem[biasIdx] <= wrByte;
		end
	end

	// register readback mux
	always @* begin
		regRead = `RST_BYTE;
		if (selRxHold) begin
			regRead = rxHoldQ[8*(idx[3:0]-4'h0)+:8];
		end else if (selTxHold) begin
			regRead = txHoldQ[8*(idx[5:0]-6'h1c)+:8];
		end else if (selLoadCtrl) begin
			regRead = {6'h00, loadBitsQ};
		end else if (selMemCtrl) begin
			regRead = memCtrlQ;
		end else if (selRxRecall) begin
			regRead = {1'b0, rxRecallIdxQ};
		end else if (selTxRecall) begin
			regRead = {1'b0, txRecallIdxQ};
		end else if (selStatus) begin
			regRead = {7'h00, stateQ};
		end
	end

	// read data: unused memory bytes and unmapped words read as zero
	always @* begin
		readNext = 32'h00000000;
		if (beamHit) begin
			case (beamByte)
				2'h0: readNext = {24'h000000, beamOld[7:0]};
				2'h1: readNext = {24'h000000, beamOld[15:8]};
				default: readNext = {24'h000000, beamOld[23:16]};
			endcase
		end else if (biasHit) begin
			readNext = {24'h000000, biasMem[biasIdx]}; // R7
		end else if (regHit) begin
			readNext = {24'h000000, regRead};
		end
	end

	// one wait cycle per access outside a recall; the write lands on the edge with waitrequest low
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			waitQ <= 1'b1;
			readDataQ <= 32'h00000000;
		end else if (busAccept) begin
			waitQ <= 1'b0;
			readDataQ <= avs_read ? readNext : 32'h00000000;
		end else begin
			waitQ <= 1'b1;
		end
	end

	// load strobes: rising edge of stored bit or of pin, one transfer each
	// a pin held high or a bit rewritten as one gives no second transfer
	assign loadRise = ~loadPinsQ & {txLoadPin, rxLoadPin}; // R13 R16
	assign doRxLoad = loadRise[0] || (wrStrobe && selLoadCtrl &&
		wrByte[`BIT_RX_LOAD] && !loadBitsQ[`BIT_RX_LOAD]); // R11 R16
	assign doTxLoad = loadRise[1] || (wrStrobe && selLoadCtrl &&
		wrByte[`BIT_TX_LOAD] && !loadBitsQ[`BIT_TX_LOAD]); // R11 R16

	// recall source word; indices past the last beam position recall zero
	assign recallIdx = {txRecallIdxQ, recallChanQ};
	assign recallValid = txRecallIdxQ <= `LAST_BEAM_POS;
	assign recallWord = recallValid ? beamMem[recallIdx] : 24'h000000;

	// control registers, holding registers and recall sequencer
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rxHoldQ <= `RST_HOLD;
			txHoldQ <= `RST_HOLD;
			loadBitsQ <= 2'h0;
			loadPinsQ <= 2'h0;
			memCtrlQ <= `RST_MEM_CTRL;
			rxRecallIdxQ <= 7'h00;
			txRecallIdxQ <= 7'h00;
			stateQ <= ST_IDLE;
			recallChanQ <= 2'h0;
		end else begin
			loadPinsQ <= {txLoadPin, rxLoadPin};
			if (wrStrobe) begin
				// bus gain/phase only reach holding with memory bypassed
				if (selRxHold && memCtrlQ[`BIT_MEM_BYPASS]) begin // R9 R19
					rxHoldQ[8*(idx[3:0]-4'h0)+:8] <= wrByte; // R11 R15
				end
				if (selTxHold && memCtrlQ[`BIT_MEM_BYPASS]) begin // R10 R19
					txHoldQ[8*(idx[5:0]-6'h1c)+:8] <= wrByte; // R11 R15
				end
				if (selLoadCtrl) begin
					loadBitsQ <= wrByte[1:0];
				end
				if (selMemCtrl) begin
					memCtrlQ <= wrByte;
				end
				if (selRxRecall) begin
					rxRecallIdxQ <= wrByte[6:0]; // R17
				end
				if (selTxRecall) begin
					txRecallIdxQ <= wrByte[6:0]; // R17
					stateQ <= ST_RECALL;
					recallChanQ <= 2'h0;
				end
			end
			case (stateQ)
				ST_IDLE: begin
					// counter rests at zero once a recall ends; nothing to do here
				end
				ST_RECALL: begin
					// one channel per cycle: gain and phase pair written in the same cycle
					// an index past the last beam position copies zeros
					txHoldQ[8*recallChanQ+:8] <= recallWord[7:0]; // R15 R18
					txHoldQ[GAIN_W+16*recallChanQ+:16] <= recallWord[23:8]; // R15 R18
					recallChanQ <= recallChanQ + 2'h1;
					if (recallChanQ == 2'h3) begin
						stateQ <= ST_IDLE;
					end
				end
				default: begin
					stateQ <= ST_IDLE;
				end
			endcase
		end
	end

	// working registers change only on a load; holding may be rewritten meanwhile
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rxWorkQ <= `RST_HOLD;
			txWorkQ <= `RST_HOLD;
		end else begin
			if (doRxLoad) begin
				rxWorkQ <= rxHoldQ; // R12 R14
			end
			if (doTxLoad) begin
				txWorkQ <= txHoldQ; // R12 R14
			end
		end
	end

	// per-channel fields of the working registers
	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : chanOut
			assign rxGainCode[7*ch+:7] = rxWorkQ[8*ch+:7]; // R8
			assign txGainCode[7*ch+:7] = txWorkQ[8*ch+:7]; // R8
			assign rxAttenuatorBypassBit[ch] = rxWorkQ[8*ch+`BIT_ATTEN_BYPASS]; // R8 R20
			assign txAttenuatorBypassBit[ch] = txWorkQ[8*ch+`BIT_ATTEN_BYPASS]; // R8 R20
		end
	endgenerate

	// working register slices go straight out; nothing is recomputed
	assign rxWorkGain = rxWorkQ[GAIN_W-1:0];
	assign rxWorkPhase = rxWorkQ[GAIN_W+:2*GAIN_W];
	assign txWorkGain = txWorkQ[GAIN_W-1:0];
	assign txWorkPhase = txWorkQ[GAIN_W+:2*GAIN_W];
	assign memBypass = memCtrlQ[`BIT_MEM_BYPASS];
	assign avs_waitrequest = waitQ;
	assign avs_readdata = readDataQ;

endmodule

// [beam_setting_consts.vh]
// offsets, field positions, sizes and reset values for the beam setting block
`ifndef BEAM_SETTING_CONSTS_VH
`define BEAM_SETTING_CONSTS_VH

// register indices (byte address on the bus is four times the index)
`define OFS_RX_HOLD_FIRST   15'h0010
`define OFS_RX_HOLD_LAST    15'h001b
`define OFS_TX_HOLD_FIRST   15'h001c
`define OFS_TX_HOLD_LAST    15'h0027
`define OFS_LOAD_CTRL       15'h0028
`define OFS_MEM_CTRL        15'h0038
`define OFS_RX_RECALL       15'h0039
`define OFS_TX_RECALL       15'h003a
`define OFS_STATUS          15'h003b
`define OFS_REG_LIMIT       15'h0040

// field positions
`define BIT_RX_LOAD         0
`define BIT_TX_LOAD         1
`define BIT_MEM_BYPASS      6
`define BIT_ATTEN_BYPASS    7
`define BIT_RECALL_BUSY     0

// address decode of the memory map
`define ADDR_CHIP_HIGH      14
`define ADDR_CHIP_LOW       13
`define ADDR_REGION_HI      12
`define ADDR_REGION_LO      11
`define TX_REGION_CODE      2'h3
`define LAST_BEAM_POS       7'h78
`define FIRST_BIAS_SLOT     7'h79
`define UNUSED_BEAM_BYTE    2'h3

// sizes
`define BYTES_PER_DIR       12
`define BEAM_ENTRIES        484
`define BIAS_BYTES_PER_SET  10
`define BIAS_BYTES          70

// reset values
`define RST_BYTE            8'h00
`define RST_HOLD            96'h0
`define RST_MEM_CTRL        8'h00

`endif

// [placeholder_none.v]
// companion file kept without logic; the whole block sits in one module

// [beam_setting_checker_properties.sv]
// concurrent checks on the bus answer and the working registers
`include "beam_setting_consts.vh"
module beam_setting_checker #(
	parameter ADDR_W = 17,
	parameter CHANNELS = 4
) (
	input	wire			clk_sys,
	input	wire			reset_n,
	input	wire [ADDR_W-1:0]	avs_address,
	input	wire			avs_read,
	input	wire			avs_write,
	input	wire [31:0]		avs_readdata,
	input	wire			avs_waitrequest,
	input	wire			rxLoadPin,
	input	wire			txLoadPin,
	input	wire [8*CHANNELS-1:0]	rxWorkGain,
	input	wire [16*CHANNELS-1:0]	rxWorkPhase,
	input	wire [8*CHANNELS-1:0]	txWorkGain,
	input	wire [16*CHANNELS-1:0]	txWorkPhase,
	input	wire [7*CHANNELS-1:0]	rxGainCode,
	input	wire [CHANNELS-1:0]	txAttenuatorBypassBit,
	input	wire			memBypass
);
	timeunit 1ns;
	timeprecision 1ps;
	// chip pins ignored here, so a load write is assumed even when refused
	wire [14:0]	idx = avs_address[16:2];
	wire		taken = avs_write && !avs_waitrequest;
	wire		loadWr = taken && {2'b00, idx[12:0]} == `OFS_LOAD_CTRL;
	wire		bypWr = taken && {2'b00, idx[12:0]} == `OFS_MEM_CTRL;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);
	wait_one_cycle_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("answer held longer than one cycle");
	answer_bound_a: assert property ((avs_read || avs_write) && avs_waitrequest
		|-> ##[0:6] !avs_waitrequest) else $error("bus answer late");
	read_byte_only_a: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
		else $error("read data above one byte");
	rx_work_hold_a: assert property (!$rose(rxLoadPin) && !loadWr
		|=> $stable(rxWorkGain) && $stable(rxWorkPhase)) else $error("rx working moved");
	tx_work_hold_a: assert property (!$rose(txLoadPin) && !loadWr
		|=> $stable(txWorkGain) && $stable(txWorkPhase)) else $error("tx working moved");
	rx_code_map_a: assert property (rxGainCode[27:21] == rxWorkGain[30:24]
		&& rxGainCode[6:0] == rxWorkGain[6:0]) else $error("gain code mismatch");
	tx_atten_map_a: assert property (txAttenuatorBypassBit == {txWorkGain[31],
		txWorkGain[23], txWorkGain[15], txWorkGain[7]}) else $error("attenuator bit mismatch");
	bypass_hold_a: assert property (!bypWr |=> $stable(memBypass))
		else $error("bypass bit moved without write");
	cover property (loadWr);
	cover property ($rose(txLoadPin));
	cover property (avs_write && avs_waitrequest [*3]);
endmodule
bind beam_setting_memory_and_load beam_setting_checker #(.ADDR_W(ADDR_W),
	.CHANNELS(CHANNELS)) u_beam_setting_checker (.clk_sys(clk_sys), .reset_n(reset_n),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.rxLoadPin(rxLoadPin), .txLoadPin(txLoadPin), .rxWorkGain(rxWorkGain),
	.rxWorkPhase(rxWorkPhase), .txWorkGain(txWorkGain), .txWorkPhase(txWorkPhase),
	.rxGainCode(rxGainCode), .txAttenuatorBypassBit(txAttenuatorBypassBit),
	.memBypass(memBypass));

// [load_pin_host.sv]
// host controller model that strobes the load pins
module load_pin_host (
	input	wire	clk_sys,
	output	logic	rxLoadPin,
	output	logic	txLoadPin
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		rxLoadPin = 1'b0;
		txLoadPin = 1'b0;
	end
	// pin held for some cycles, then low a full cycle so the next rise is seen
	task automatic strobe(input bit tx, input int hold);
		@(posedge clk_sys);
		if (tx) txLoadPin <= 1'b1;
		else rxLoadPin <= 1'b1;
		repeat (hold) @(posedge clk_sys);
		txLoadPin <= 1'b0;
		rxLoadPin <= 1'b0;
		@(posedge clk_sys);
	endtask
endmodule

// [test_beam_setting_memory_and_load.sv]
// self-checking bench for the beam setting block
`include "beam_setting_consts.vh"
module test_beam_setting_memory_and_load;
	timeunit 1ns;
	timeprecision 1ps;
	logic		clk_sys = 1'b0;
	logic		reset_n = 1'b0;
	logic [16:0]	adr = 17'h0;
	logic		rd = 1'b0;
	logic		wr = 1'b0;
	logic [31:0]	wd = 32'h0;
	logic [3:0]	be = 4'hf;
	logic		pinLo = 1'b0;
	logic		pinHi = 1'b1;
	wire [31:0]	rdat;
	wire		wreq;
	wire		rxPin;
	wire		txPin;
	wire		mbp;
	wire [31:0]	rxG;
	wire [31:0]	txG;
	wire [63:0]	rxP;
	wire [63:0]	txP;
	wire [27:0]	rxC;
	wire [3:0]	rxA;
	wire [27:0]	txC;
	wire [3:0]	txA;
	logic [63:0]	got;
	logic [31:0]	expG;
	logic [63:0]	expP;
	logic [27:0]	expC;
	logic [3:0]	expA;
	int		fails = 0;
	int		checks_done = 0;
	always #12.5 clk_sys = ~clk_sys;
	beam_setting_memory_and_load u_beam_setting_memory_and_load (.clk_sys(clk_sys),
		.reset_n(reset_n), .avs_address(adr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
		.avs_waitrequest(wreq), .chipAddrPinLow(pinLo), .chipAddrPinHigh(pinHi),
		.rxLoadPin(rxPin), .txLoadPin(txPin), .rxWorkGain(rxG), .rxWorkPhase(rxP),
		.txWorkGain(txG), .txWorkPhase(txP), .rxGainCode(rxC), .txGainCode(txC),
		.rxAttenuatorBypassBit(rxA), .txAttenuatorBypassBit(txA), .memBypass(mbp));
	load_pin_host u_load_pin_host (.clk_sys(clk_sys), .rxLoadPin(rxPin), .txLoadPin(txPin));
	task automatic report_and_stop();
		if (fails == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one bus access, held until waitrequest is sampled low
	task automatic acc(input bit w, input logic [14:0] idx, input logic [7:0] d);
		adr <= {idx, 2'b00};
		wd <= {24'h0, d};
		rd <= !w;
		wr <= w;
		@(posedge clk_sys);
		while (wreq !== 1'b0) @(posedge clk_sys);
		got = {32'h0, rdat};
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic wrR(input logic [14:0] o, input logic [7:0] d);
		acc(1'b1, {pinHi, pinLo, o[12:0]}, d);
	endtask
	task automatic rdR(input logic [14:0] o);
		acc(1'b0, {pinHi, pinLo, o[12:0]}, 8'h00);
	endtask
	function automatic logic [14:0] mi(input logic [6:0] pos, input logic [3:0] lo);
		return {pinHi, pinLo, 2'b11, pos, lo};
	endfunction
	// fill a holding bank, show it is not live yet, then load it
	task automatic fillLoad(input bit tx, input logic [7:0] base);
		logic [7:0] d;
		for (int i = 0; i < 12; i++) begin
			d = base ^ 8'(i * 8'h47);
			wrR((tx ? `OFS_TX_HOLD_FIRST : `OFS_RX_HOLD_FIRST) + 15'(i), d);
			if (i < 4) begin
				expG[8*i+:8] = d;
				expC[7*i+:7] = d[6:0];
				expA[i] = d[7];
			end else
				expP[8*(i-4)+:8] = d;
		end
		chk("gain before load", 64'(tx ? txG : rxG), 64'h0);
		if (tx) u_load_pin_host.strobe(1'b1, 2);
		else wrR(`OFS_LOAD_CTRL, 8'h01);
		chk("work gain", 64'(tx ? txG : rxG), 64'(expG));
		chk("work phase", tx ? txP : rxP, expP);
		chk("gain code", 64'(tx ? txC : rxC), 64'(expC));
		chk("attenuator bits", 64'(tx ? txA : rxA), 64'(expA));
	endtask
	// watchdog well beyond the few hundred cycles the run needs
	initial begin
		#(25ns * 20000);
		fails++;
		report_and_stop();
	end
	initial begin
		repeat (10) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		// bypass still low: a gain write must not land
		wrR(`OFS_RX_HOLD_FIRST, 8'h5a);
		wrR(`OFS_LOAD_CTRL, 8'h01);
		chk("gain with bypass low", 64'(rxG), 64'h0);
		wrR(`OFS_LOAD_CTRL, 8'h00);
		wrR(`OFS_MEM_CTRL, 8'h40);
		chk("bypass bit", 64'(mbp), 64'h1);
		fillLoad(1'b0, 8'h83);
		// stored load bit still one, so no new transfer; bad byteenable is ignored
		wrR(`OFS_RX_HOLD_FIRST, 8'h11);
		be <= 4'he;
		wrR(`OFS_RX_HOLD_FIRST, 8'h33);
		be <= 4'hf;
		wrR(`OFS_LOAD_CTRL, 8'h01);
		chk("gain held", 64'(rxG), 64'(expG));
		wrR(`OFS_LOAD_CTRL, 8'h00);
		wrR(`OFS_LOAD_CTRL, 8'h01);
		chk("gain reloaded", 64'(rxG[7:0]), 64'h11);
		rdR(`OFS_RX_HOLD_FIRST);
		chk("rx holding readback", got, 64'h11);
		wrR(`OFS_RX_RECALL, 8'h2a);
		rdR(`OFS_RX_RECALL);
		chk("rx recall index", got, 64'h2a);
		fillLoad(1'b1, 8'h05);
		// beam entry at the last position, bias slots, unused and foreign bytes
		for (int c = 0; c < 4; c++)
			for (int b = 0; b < 3; b++)
				acc(1'b1, mi(7'd120, 4'(4 * c + b)), 8'(16 * c + b + 1));
		acc(1'b1, mi(7'd120, 4'd7), 8'hff);
		acc(1'b0, mi(7'd120, 4'd7), 8'h00);
		chk("unused byte", got, 64'h0);
		acc(1'b0, mi(7'd120, 4'd14), 8'h00);
		chk("beam byte", got, 64'h33);
		acc(1'b1, mi(7'd127, 4'd13), 8'h5c);
		acc(1'b0, mi(7'd127, 4'd13), 8'h00);
		chk("last bias byte", got, 64'h5c);
		acc(1'b1, mi(7'd121, 4'd3), 8'h6b);
		acc(1'b0, mi(7'd121, 4'd3), 8'h00);
		chk("bias gap byte", got, 64'h0);
		acc(1'b1, mi(7'd120, 4'd0) ^ 15'h2000, 8'h77);
		acc(1'b0, mi(7'd120, 4'd0), 8'h00);
		chk("other chip write", got, 64'h01);
		// recall position 120 into tx holding; live only after the load pin
		wrR(`OFS_TX_RECALL, 8'd120);
		wrR(`OFS_STATUS, 8'h00);
		chk("recall before load", 64'(txG), 64'(expG));
		rdR(`OFS_TX_HOLD_FIRST + 15'h4);
		chk("recalled holding byte", got, 64'h02);
		rdR(`OFS_STATUS);
		chk("recall done", got, 64'h0);
		u_load_pin_host.strobe(1'b1, 3);
		for (int c = 0; c < 4; c++) begin
			expG[8*c+:8] = 8'(16 * c + 1);
			expP[16*c+:16] = {8'(16 * c + 3), 8'(16 * c + 2)};
		end
		chk("recalled gain", 64'(txG), 64'(expG));
		chk("recalled phase", txP, expP);
		report_and_stop();
	end
endmodule
